/* lvds_fmt_map.vh */
`ifndef LVDS_FMT_MAP_VH
`define LVDS_FMT_MAP_VH
// ***********************************************
// register offsets
// ***********************************************
`define REG_INV_LOW 12'h111
`define REG_INV_HIGH 12'h112
`define REG_PDN_UPPER_A 12'h113
`define REG_PDN_UPPER_B 12'h114
`define REG_FRAME_CLOCK_CTRL 12'h115
`define REG_MUX_SCR_CTRL 12'h116
`define REG_LANE_SEL_BASE 12'h117
`define REG_LANE_SEL_LAST 12'h11E
`define REG_OVR_LENGTH 12'h10B
// ***********************************************
// field positions and reset values
// ***********************************************
`define FRAME_CLOCK_DUTY_BIT 3
`define FRAME_CLOCK_DISABLE_BIT 2
`define MUX_EN_BIT 7
`define SWAP_EDGE_BIT 6
`define SCR_MSB 2
`define SCR_LSB 0
`define RST_CTRL 8'h00
`define RST_OVR_LENGTH 8'h0F
`define SCR_NONE 3'h0
`define SCR_PRBS_LSB 3'h1
`define SCR_OVR_LSB 3'h2
`define SCR_OVR_LSB1 3'h3
`define SCR_PRBS_LSB1 3'h4
`define SCR_OVR1_PRBS0 3'h5
`define SCR_OVR2_PRBS1 3'h6
`define LFSR_SEED 31'h00000001
`endif

/* lvds_sample_scrambler.v */
`timescale 1ns/10ps
`include "lvds_fmt_map.vh"
// ***********************************************
// per-sample scrambling and over-range insertion
// ***********************************************
module lvds_sample_scrambler #(
    parameter W = 16
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire step_in,
    input wire [W-1:0] sample_in,
    input wire ovr_in,
    input wire [2:0] mode_in,
    output reg [W-1:0] word_out
);
    reg [30:0] lfsr_q;
    reg [W-1:0] w;
    wire prbs;
    assign prbs = lfsr_q[30];

    // 31-bit maximal lfsr, one step per sample
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lfsr_q <= `LFSR_SEED;
        end else if (step_in) begin
            lfsr_q <= {lfsr_q[29:0], lfsr_q[30] ^ lfsr_q[27]};
        end
    end

    always @* begin
        w = sample_in;
        case (mode_in)
            `SCR_PRBS_LSB: begin
                w = sample_in ^ {W{prbs}};
                w[0] = prbs;
            end
            `SCR_OVR_LSB: w[0] = ovr_in;
            `SCR_OVR_LSB1: w[1] = ovr_in;
            `SCR_PRBS_LSB1: begin
                w = sample_in ^ {W{prbs}};
                w[1] = prbs;
            end
            `SCR_OVR1_PRBS0: begin
                w = sample_in ^ {W{prbs}};
                w[1] = ovr_in;
                w[0] = prbs;
            end
            `SCR_OVR2_PRBS1: begin
                w = sample_in ^ {W{prbs}};
                w[2] = ovr_in;
                w[1] = prbs;
            end
            default: w = sample_in;
        endcase
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            word_out <= {W{1'b0}};
        end else if (step_in) begin
            word_out <= w;
        end
    end
endmodule

/* lvds_output_format_ctrl.v */
// Contract
// - one polarity invert bit per lane
// - low reg lanes 7..0, high reg lanes 8..15
// - upper power-down bit tri-states lane
// - first upper register D7 is lane 14
// - duty select: one bit-clock or half sample
// - frame clock rides lane 0 in LSB slot
// - disable bit sends LSB data on lane 0
// - mux enable applies lane source selects
// - edge swap exchanges rising/falling bits
// - scramble 000 none, 111 unused
// - 001 xor prbs, prbs at LSB
// - 010 ovr at LSB, 011 at LSB+1
// - 100 xor prbs, prbs at LSB+1
// - 101 ovr LSB+1, prbs LSB, xor
// - 110 ovr LSB+2, prbs LSB+1, xor
// - prbs from a long lfsr
// - lane select N routes bus lane N
// - over-range stretched to length plus one
`timescale 1ns/10ps
`include "lvds_fmt_map.vh"
module lvds_output_format_ctrl #(
    parameter LANES = 16
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire [11:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire bit_clock_in,
    input wire sample_valid_in,
    input wire [LANES*16-1:0] sample_in,
    input wire ovr_in,
    output reg [LANES-1:0] lane_data_out,
    output reg [LANES-1:0] lane_oe_out,
    output reg frame_clock_out
);
    // ***********************************************
    // registers
    // ***********************************************
    reg [7:0] inv_low_q;
    reg [7:0] inv_high_q;
    reg [7:0] pdn_a_q;
    reg [7:0] pdn_b_q;
    reg [7:0] frame_clock_ctrl_q;
    reg [7:0] mux_ctrl_q;
    reg [7:0] ovr_len_q;
    reg [3:0] sel_q [0:LANES-1];
    integer i;

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            inv_low_q <= `RST_CTRL;
            inv_high_q <= `RST_CTRL;
            pdn_a_q <= `RST_CTRL;
            pdn_b_q <= `RST_CTRL;
            frame_clock_ctrl_q <= `RST_CTRL;
            mux_ctrl_q <= `RST_CTRL;
            ovr_len_q <= `RST_OVR_LENGTH;
            for (i = 0; i < LANES; i = i + 1) begin
                sel_q[i] <= 4'h0;
            end
        end else if (wr_in) begin
            if (addr_in == `REG_INV_LOW) begin
                inv_low_q <= wdata_in;
            end else if (addr_in == `REG_INV_HIGH) begin
                inv_high_q <= wdata_in;
            end else if (addr_in == `REG_PDN_UPPER_A) begin
                pdn_a_q <= wdata_in;
            end else if (addr_in == `REG_PDN_UPPER_B) begin
                pdn_b_q <= wdata_in;
            end else if (addr_in == `REG_FRAME_CLOCK_CTRL) begin
                frame_clock_ctrl_q <= wdata_in;
            end else if (addr_in == `REG_MUX_SCR_CTRL) begin
                mux_ctrl_q <= wdata_in;
            end else if (addr_in == `REG_OVR_LENGTH) begin
                ovr_len_q <= wdata_in;
            end else if (addr_in >= `REG_LANE_SEL_BASE && addr_in <= `REG_LANE_SEL_LAST) begin
                for (i = 0; i < LANES / 2; i = i + 1) begin
                    if (addr_in == `REG_LANE_SEL_BASE + i) begin
                        sel_q[2*i] <= wdata_in[3:0];
                        sel_q[2*i+1] <= wdata_in[7:4];
                    end
                end
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    reg [7:0] rd_d;
    reg [11:0] sel_idx;
    always @* begin
        rd_d = 8'h00;
        sel_idx = addr_in - `REG_LANE_SEL_BASE;
        if (addr_in == `REG_INV_LOW) begin
            rd_d = inv_low_q;
        end else if (addr_in == `REG_INV_HIGH) begin
            rd_d = inv_high_q;
        end else if (addr_in == `REG_PDN_UPPER_A) begin
            rd_d = pdn_a_q;
        end else if (addr_in == `REG_PDN_UPPER_B) begin
            rd_d = pdn_b_q;
        end else if (addr_in == `REG_FRAME_CLOCK_CTRL) begin
            rd_d = frame_clock_ctrl_q;
        end else if (addr_in == `REG_MUX_SCR_CTRL) begin
            rd_d = mux_ctrl_q;
        end else if (addr_in == `REG_OVR_LENGTH) begin
            rd_d = ovr_len_q;
        end else if (addr_in >= `REG_LANE_SEL_BASE && addr_in <= `REG_LANE_SEL_LAST) begin
            rd_d = {sel_q[{sel_idx[2:0], 1'b1}], sel_q[{sel_idx[2:0], 1'b0}]};
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rd_d : 8'h00;
        end
    end

    // ***********************************************
    // bit clock sampling
    // ***********************************************
    reg bclk_s1_q, bclk_s2_q, bclk_s3_q;
    reg ovr_s1_q, ovr_s2_q;
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
            ovr_s1_q <= 1'b0;
            ovr_s2_q <= 1'b0;
        end else begin
            bclk_s1_q <= bit_clock_in;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
            ovr_s1_q <= ovr_in;
            ovr_s2_q <= ovr_s1_q;
        end
    end
    wire bclk_rise = bclk_s2_q & ~bclk_s3_q;
    wire bclk_fall = ~bclk_s2_q & bclk_s3_q;

    // ***********************************************
    // over-range stretch
    // ***********************************************
    reg [8:0] ovr_cnt_q;
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ovr_cnt_q <= 9'h000;
        end else if (ovr_s2_q) begin
            ovr_cnt_q <= {1'b0, ovr_len_q} + 9'h001;
        end else if (ovr_cnt_q != 9'h000) begin
            ovr_cnt_q <= ovr_cnt_q - 9'h001;
        end
    end
    wire ovr_stretched = ovr_cnt_q != 9'h000;

    // ***********************************************
    // per-lane scramble, 16 bits per lane word
    // ***********************************************
    wire [LANES*16-1:0] scr_word;
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane_scr
            lvds_sample_scrambler #(
                .W(16)
            ) u_scr (
                .core_clk_in(core_clk_in),
                .nrst_in(nrst_in),
                .step_in(sample_valid_in),
                .sample_in(sample_in[g*16 +: 16]),
                .ovr_in(ovr_stretched),
                .mode_in(mux_ctrl_q[`SCR_MSB:`SCR_LSB]),
                .word_out(scr_word[g*16 +: 16])
            );
        end
    endgenerate

    // ***********************************************
    // serializer: 8 bit-clock periods per word, DDR
    // ***********************************************
    reg [LANES*16-1:0] shift_q;
    reg [2:0] bit_cnt_q;
    reg load_pend_q;
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            load_pend_q <= 1'b0;
        end else if (sample_valid_in) begin
            load_pend_q <= 1'b1;
        end else if (bclk_rise && bit_cnt_q == 3'h7) begin
            load_pend_q <= 1'b0;
        end
    end

    // lane source select with mux enable
    function [15:0] pick;
        input [LANES*16-1:0] bus;
        input [3:0] idx;
        begin
            pick = bus[idx*16 +: 16];
        end
    endfunction

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_q <= {LANES*16{1'b0}};
            bit_cnt_q <= 3'h0;
        end else if (bclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7 && load_pend_q) begin
                for (i = 0; i < LANES; i = i + 1) begin
                    if (mux_ctrl_q[`MUX_EN_BIT]) begin
                        shift_q[i*16 +: 16] <= pick(scr_word, sel_q[i]);
                    end else begin
                        shift_q[i*16 +: 16] <= scr_word[i*16 +: 16];
                    end
                end
            end else begin
                for (i = 0; i < LANES; i = i + 1) begin
                    shift_q[i*16 +: 16] <= {shift_q[i*16 +: 14], 2'b00};
                end
            end
        end
    end

    // ***********************************************
    // lane outputs
    // ***********************************************
    wire [LANES-1:0] inv_vec;
    wire [LANES-1:0] pdn_vec;
    // 0x112 D7..D0 -> lanes 8..15
    assign inv_vec = {inv_high_q[0], inv_high_q[1], inv_high_q[2], inv_high_q[3],
                      inv_high_q[4], inv_high_q[5], inv_high_q[6], inv_high_q[7],
                      inv_low_q};
    // first upper register D7..D1 -> lanes 14..8, its D0 unused; second register D0 -> lane 15
    assign pdn_vec = {pdn_b_q[0], pdn_a_q[7:1], 8'h00};

    wire frame_clock_disable = frame_clock_ctrl_q[`FRAME_CLOCK_DISABLE_BIT];
    wire last_slot = bit_cnt_q == 3'h7;
    wire frame_clock_now = frame_clock_ctrl_q[`FRAME_CLOCK_DUTY_BIT] ? (bit_cnt_q < 3'h4) :
                    (bit_cnt_q == 3'h0);

    reg [LANES-1:0] bits_d;
    reg msb_bit, lsb_bit, first, second;
    always @* begin
        bits_d = {LANES{1'b0}};
        msb_bit = 1'b0;
        lsb_bit = 1'b0;
        first = 1'b0;
        second = 1'b0;
        for (i = 0; i < LANES; i = i + 1) begin
            msb_bit = shift_q[i*16 + 15];
            lsb_bit = shift_q[i*16 + 14];
            if (i == 0 && last_slot && !frame_clock_disable) begin
                lsb_bit = frame_clock_now;
            end
            first = mux_ctrl_q[`SWAP_EDGE_BIT] ? lsb_bit : msb_bit;
            second = mux_ctrl_q[`SWAP_EDGE_BIT] ? msb_bit : lsb_bit;
            bits_d[i] = (bclk_s2_q ? first : second) ^ inv_vec[i];
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lane_data_out <= {LANES{1'b0}};
            lane_oe_out <= {LANES{1'b0}};
            frame_clock_out <= 1'b0;
        end else begin
            lane_data_out <= bits_d & ~pdn_vec;
            lane_oe_out <= ~pdn_vec;
            frame_clock_out <= frame_clock_now & ~frame_clock_disable;
        end
    end

    wire unused_fall = bclk_fall;
endmodule

/* lvds_fmt_asserts.sv */
`timescale 1ns/10ps
`include "lvds_fmt_map.vh"
module lvds_fmt_asserts #(
    parameter LANES = 16
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire [11:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire bit_clock_in,
    input wire sample_valid_in,
    input wire [LANES*16-1:0] sample_in,
    input wire ovr_in,
    input wire [LANES-1:0] lane_data_out,
    input wire [LANES-1:0] lane_oe_out,
    input wire frame_clock_out
);
    // ********
    // shadow of frame clock control and pulse length
    // ********
    reg [7:0] frame_clock_q;
    reg arm_q;
    reg [7:0] hi_q;
    wire fc_wr = wr_in && addr_in == `REG_FRAME_CLOCK_CTRL;
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            frame_clock_q <= 8'h00;
            arm_q <= 1'b0;
            hi_q <= 8'h00;
        end else begin
            if (fc_wr) begin
                frame_clock_q <= wdata_in;
            end
            // first pulse after a change may be cut short
            arm_q <= !fc_wr && (arm_q || $fell(frame_clock_out));
            hi_q <= frame_clock_out ? hi_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_off14;
        wr_in && addr_in == `REG_PDN_UPPER_A && wdata_in[7];
    endsequence
    sequence s_on14;
        wr_in && addr_in == `REG_PDN_UPPER_A && !wdata_in[7];
    endsequence
    a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_read_frame_clock: assert property (rd_in && addr_in == `REG_FRAME_CLOCK_CTRL |=> rdata_out == $past(frame_clock_q))
        else $error("frame control readback wrong");
    a_read_unmap: assert property (rd_in && addr_in == 12'h000 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_oe_lower: assert property ($past(nrst_in) |-> &lane_oe_out[7:0])
        else $error("lower lane released");
    a_pdn_off: assert property (s_off14 |-> ##[1:3] !lane_oe_out[14])
        else $error("lane 14 not powered down");
    a_pdn_on: assert property (s_on14 |-> ##[1:3] lane_oe_out[14])
        else $error("lane 14 not restored");
    a_pd_quiet: assert property (!lane_oe_out[15] |-> !lane_data_out[15])
        else $error("released lane toggles");
    a_frame_clock_off: assert property (frame_clock_q[2] && $past(frame_clock_q[2], 4) |-> !frame_clock_out)
        else $error("frame clock while disabled");
    a_frame_clock_short: assert property ($fell(frame_clock_out) && arm_q && !frame_clock_q[3]
        |-> hi_q inside {[8'h0A:8'h10]}) else $error("short frame pulse length");
    a_frame_clock_half: assert property ($fell(frame_clock_out) && arm_q && frame_clock_q[3]
        |-> hi_q inside {[8'h30:8'h36]}) else $error("half frame pulse length");
endmodule
bind lvds_output_format_ctrl lvds_fmt_asserts #(.LANES(LANES)) i_lvds_fmt_asserts (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .bit_clock_in(bit_clock_in), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .ovr_in(ovr_in), .lane_data_out(lane_data_out),
    .lane_oe_out(lane_oe_out), .frame_clock_out(frame_clock_out));

/* lvds_lane_rx.sv */
`timescale 1ns/10ps
// ********
// receiver: notes which levels each driven lane showed
// ********
module lvds_lane_rx (
    input wire core_clk_in,
    input wire clr_in,
    input wire [15:0] lane_data_in,
    input wire [15:0] lane_oe_in,
    output reg [15:0] seen1_out,
    output reg [15:0] seen0_out
);
    always @(posedge core_clk_in) begin
        if (clr_in) begin
            seen1_out <= 16'h0000;
            seen0_out <= 16'h0000;
        end else begin
            // a released lane carries nothing
            seen1_out <= seen1_out | (lane_data_in & lane_oe_in);
            seen0_out <= seen0_out | (~lane_data_in & lane_oe_in);
        end
    end
endmodule

/* test_lvds_output_format_ctrl.sv */
`timescale 1ns/10ps
`include "lvds_fmt_map.vh"
module test_lvds_output_format_ctrl;
    reg core_clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg [11:0] addr_in = 12'h000;
    reg [7:0] wdata_in = 8'h00;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg bit_clock_in = 1'b0;
    reg sample_valid_in = 1'b0;
    reg [255:0] sample_in = 256'h0;
    reg ovr_in = 1'b0;
    reg clr = 1'b1;
    reg [6:0] vcnt = 7'h00;
    wire [7:0] rdata_out;
    wire [15:0] lane_data_out;
    wire [15:0] lane_oe_out;
    wire [15:0] seen1;
    wire [15:0] seen0;
    wire frame_clock_out;
    wire [47:0] tv = 48'hA53C81010CC6;
    integer n_fail = 0;
    integer n_tests = 0;
    integer m;
    always #2.5 core_clk_in = ~core_clk_in;
    always #32 bit_clock_in = ~bit_clock_in;
    // one new sample word every 102 cycles
    always @(posedge core_clk_in) begin
        vcnt <= (vcnt == 7'h65) ? 7'h00 : vcnt + 7'h01;
        sample_valid_in <= (vcnt == 7'h00);
    end
    lvds_output_format_ctrl #(.LANES(16)) i_lvds_output_format_ctrl (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .bit_clock_in(bit_clock_in), .sample_valid_in(sample_valid_in),
        .sample_in(sample_in), .ovr_in(ovr_in), .lane_data_out(lane_data_out),
        .lane_oe_out(lane_oe_out), .frame_clock_out(frame_clock_out));
    lvds_lane_rx i_lvds_lane_rx (.core_clk_in(core_clk_in), .clr_in(clr),
        .lane_data_in(lane_data_out), .lane_oe_in(lane_oe_out),
        .seen1_out(seen1), .seen0_out(seen0));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge core_clk_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            @(posedge core_clk_in);
            wr_in <= 1'b0;
        end
    endtask
    task rd_chk(input [11:0] a, input [7:0] e);
        begin
            @(posedge core_clk_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge core_clk_in);
            rd_in <= 1'b0;
            #1 chk({8'h00, rdata_out}, {8'h00, e});
        end
    endtask
    // the six configuration bytes are written as given; tv sets the unused D0 of 0x113
    task cfg(input [47:0] v);
        integer k;
        begin
            for (k = 0; k < 6; k = k + 1) begin
                wr(12'h111 + k, v[47 - 8 * k -: 8]);
            end
        end
    endtask
    // let settings settle, then watch n samples
    task watch(input integer n, input [15:0] e1, input [15:0] e0);
        begin
            repeat (250) @(posedge core_clk_in);
            clr <= 1'b0;
            repeat (n * 102) @(posedge core_clk_in);
            #1 chk(seen1, e1);
            chk(seen0, e0);
            clr <= 1'b1;
        end
    endtask
    task t_regs;
        begin
            rd_chk(`REG_FRAME_CLOCK_CTRL, 8'h00);
            rd_chk(`REG_MUX_SCR_CTRL, 8'h00);
            cfg(tv);
            for (m = 0; m < 6; m = m + 1) begin
                rd_chk(12'h111 + m, tv[47 - 8 * m -: 8]);
            end
            wr(12'h000, 8'hFF);
            rd_chk(12'h000, 8'h00);
        end
    endtask
    task t_pdn;
        begin
            cfg(48'h000080010400);
            repeat (4) @(posedge core_clk_in);
            #1 chk(lane_oe_out, 16'h3FFF);
            watch(2, 16'h0000, 16'h3FFF);
        end
    endtask
    task t_mux;
        begin
            sample_in <= 256'hFFFF << 48;
            cfg(48'h000000000400);
            watch(2, 16'h0008, 16'hFFF7);
            wr(12'h117, 8'h30);
            wr(`REG_MUX_SCR_CTRL, 8'h80);
            watch(2, 16'h0002, 16'hFFFD);
            wr(`REG_MUX_SCR_CTRL, 8'h00);
            sample_in <= 256'h0;
        end
    endtask
    task t_scr;
        begin
            ovr_in <= 1'b1;
            for (m = 0; m < 7; m = m + 1) begin
                wr(`REG_MUX_SCR_CTRL, m[7:0]);
                watch(40, (m == 0) ? 16'h0000 : 16'hFFFF, 16'hFFFF);
            end
            ovr_in <= 1'b0;
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        t_regs;
        t_pdn;
        // lane 0 carries all ones: its lsb slot shows the frame clock or the data
        sample_in <= 256'hFFFF;
        cfg(48'h028000000400);
        watch(2, 16'h0103, 16'hFEFC);
        cfg(48'h000000000000);
        watch(2, 16'h0001, 16'hFFFF);
        wr(`REG_FRAME_CLOCK_CTRL, 8'h08);
        watch(3, 16'h0001, 16'hFFFF);
        sample_in <= 256'h0;
        t_mux;
        t_scr;
        conclude;
    end
    initial begin
        #400000;
        n_fail = n_fail + 1;
        conclude;
    end
endmodule
